//--- verilog/uac_pkg.sv
package uac_pkg;
	// register byte offsets
	localparam logic [11:0] UAC_AFE_CTRL_OFS   = 12'h0C8;
	localparam logic [11:0] UAC_LINK_CFG_OFS   = 12'h140;
	localparam logic [11:0] UAC_IRQ_STAT_OFS   = 12'h200;
	localparam logic [11:0] UAC_IRQ_EN_OFS     = 12'h204;
	localparam logic [11:0] UAC_IRQ_CLR_OFS    = 12'h208;
	// upstream afe control fields
	localparam int UAC_TERM_BIT     = 29;
	localparam int UAC_SQUELCH_BIT  = 28;
	localparam int UAC_DISC_BIT     = 27;
	localparam int UAC_TUNE_LSB     = 24;
	localparam int UAC_TUNE_MSB     = 26;
	// chip link port config fields
	localparam int UAC_MODE_BIT     = 24;
	localparam int UAC_IMP_BIT      = 18;
	localparam int UAC_SLEW_BIT     = 17;
	localparam int UAC_SWAP_BIT     = 16;
	// interrupt status bits
	localparam int UAC_IRQ_SQ_BIT   = 0;
	localparam int UAC_IRQ_DISC_BIT = 1;
	localparam logic [1:0] UAC_IRQ_MASK = 2'h3;
	// reset values
	localparam logic [2:0] UAC_TUNE_RST = 3'h0;
	localparam logic       UAC_BIT_RST  = 1'h0;
	// axi responses
	localparam logic [1:0] UAC_RESP_OKAY   = 2'h0;
	localparam logic [1:0] UAC_RESP_SLVERR = 2'h2;
endpackage

//--- verilog/uac_img_sel.sv
`timescale 1ns/1ps
// picks the image default: eeprom first, then otp, else zero
module uac_img_sel
	import uac_pkg::*;
(
	input  wire logic       eepromPresent,
	input  wire logic       otpPresent,
	input  wire logic [5:0] eepromBits,
	input  wire logic [5:0] otpBits,
	output logic      [5:0] imageBits
);
	// bit layout: [5:3] squelch tune, [2] impedance, [1] slew, [0] swap
	always_comb begin
		if (eepromPresent) begin
			imageBits = eepromBits; // R6 R13
		end else if (otpPresent) begin
			imageBits = otpBits; // R6 R13
		end else begin
			imageBits = {UAC_TUNE_RST, UAC_BIT_RST, UAC_BIT_RST, UAC_BIT_RST};
		end
	end
endmodule

//--- verilog/uac_regs.sv
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
// Contract
// R1 - termination output follows writable bit 29 of afe control, reset 0.
// R2 - bit 28 read-only squelch, 0 while high-speed data valid.
// R3 - bit 27 read-only disconnect flag; valid only at EOP bit 32.
// R4 - bits 26:24 squelch trip tune code drive the analog front end.
// R5 - squelch tune survives resets covered by reset protection.
// R6 - squelch tune defaults from eeprom, else otp, else zero.
// R7 - usb or lite reset reloads every image field from last image; the code keeps tune instead while reset protection is set.
// R8 - link config bit 24 selects usb (0) or chip-to-chip mode (1).
// R9 - mode select resets to the value of the mode strap pin.
// R10 - bit 18 picks 40 ohm (0) or 50 ohm (1) driver.
// R11 - bit 17 adjusts data/strobe slew by 30 percent when set.
// R12 - bit 16 swaps data and strobe pin roles when set.
// R13 - impedance, slew, swap default from eeprom, else otp, else zero.
// R14 - reserved bits read zero and ignore writes.
module uac_regs
	import uac_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// axi4-lite slave
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// configuration image and resets
	input  wire logic        eepromPresent,
	input  wire logic        otpPresent,
	input  wire logic [5:0]  eepromBits,
	input  wire logic [5:0]  otpBits,
	input  wire logic        imageLoad,
	input  wire logic        usbReset,
	input  wire logic        liteReset,
	input  wire logic        resetProtect,
	input  wire logic        portModeStrapPin,
	// analog front end status
	input  wire logic        afeSquelchN,
	input  wire logic        afeDisconnect,
	input  wire logic        eopBit32,
	// analog front end and link controls
	output logic             hsTerminationEnable,
	output logic [2:0]       squelchTripTune,
	output logic             portModeSelect,
	output logic             driverImpedanceSelect,
	output logic             driverSlewAdjust,
	output logic             dataStrobeSwap,
	output logic             irq
);
	// write response state
	typedef enum logic [1:0] {
		UAC_W_IDLE,
		UAC_W_RESP
	} uac_wst_e;

	// all module state in one packed word, registered in one place
	typedef struct packed {
		uac_wst_e    wSt;
		logic        awHave;
		logic [11:0] awAddr;
		logic        wHave;
		logic [31:0] wData;
		logic [3:0]  wStrb;
		logic        bValid;
		logic [1:0]  bResp;
		logic        rValid;
		logic [31:0] rData;
		logic [1:0]  rResp;
		logic        strapDone;
		logic [5:0]  image;
		logic        term;
		logic        squelchN;
		logic        disc;
		logic [2:0]  tune;
		logic        mode;
		logic        imp;
		logic        slew;
		logic        swap;
		logic [1:0]  irqStat;
		logic [1:0]  irqEn;
		logic        irqOut;
		logic        awRdy;
		logic        wRdy;
		logic        arRdy;
	} uac_state_s;

	// registered state and its next value
	uac_state_s st_r;
	uac_state_s st_nxt;
	logic [5:0] imageSel;

	// image source priority lives in its own small block
	uac_img_sel u_img (
		.eepromPresent (eepromPresent),
		.otpPresent    (otpPresent),
		.eepromBits    (eepromBits),
		.otpBits       (otpBits),
		.imageBits     (imageSel)
	);

	// merges write data into a register under byte strobes
	function automatic logic [31:0] uac_merge(input logic [31:0] old,
			input logic [31:0] dat, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = dat[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// a write slot is free when empty and no response is waiting; the
	// take conditions and the ready flops share this one test
	function automatic logic uac_slot_free(input logic have,
			input uac_wst_e wst);
		return !have && wst == UAC_W_IDLE;
	endfunction

	// register image for reads; reserved bits stay zero
	function automatic logic [31:0] uac_read(input uac_state_s s,
			input logic [11:0] a, output logic ok);
		logic [31:0] v;
		v = 32'h0; // R14
		ok = 1'b1;
		// unmapped offsets answer with an error and zero data
		case (a)
			UAC_AFE_CTRL_OFS: begin
				v[UAC_TERM_BIT] = s.term;
				v[UAC_SQUELCH_BIT] = s.squelchN; // R2
				v[UAC_DISC_BIT] = s.disc; // R3
				v[UAC_TUNE_MSB:UAC_TUNE_LSB] = s.tune;
			end
			UAC_LINK_CFG_OFS: begin
				v[UAC_MODE_BIT] = s.mode;
				v[UAC_IMP_BIT] = s.imp;
				v[UAC_SLEW_BIT] = s.slew;
				v[UAC_SWAP_BIT] = s.swap;
			end
			UAC_IRQ_STAT_OFS: v[1:0] = s.irqStat;
			UAC_IRQ_EN_OFS: v[1:0] = s.irqEn;
			UAC_IRQ_CLR_OFS: v = 32'h0; // write-only
			default: ok = 1'b0;
		endcase
		return v;
	endfunction

	// next-state logic: bus slave, field updates, status capture
	always_comb begin
		logic [31:0] m;
		logic        ok;
		logic        doWr;
		logic [1:0]  setEv;
		logic [1:0]  clrEv;
		logic        sqNew;
		logic        discNew;
		m = 32'h0;
		ok = 1'b0;
		doWr = 1'b0;
		setEv = 2'h0;
		clrEv = 2'h0;
		sqNew = 1'b0;
		discNew = 1'b0;
		st_nxt = st_r;

		// write address and data are taken in either order
		if (s_axi_awvalid && uac_slot_free(st_r.awHave, st_r.wSt)) begin
			st_nxt.awHave = 1'b1;
			st_nxt.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && uac_slot_free(st_r.wHave, st_r.wSt)) begin
			st_nxt.wHave = 1'b1;
			st_nxt.wData = s_axi_wdata;
			st_nxt.wStrb = s_axi_wstrb;
		end
		// response is raised the cycle after both halves are held
		if (st_r.wSt == UAC_W_IDLE && st_r.awHave && st_r.wHave) begin
			doWr = 1'b1;
			st_nxt.awHave = 1'b0;
			st_nxt.wHave = 1'b0;
			st_nxt.bValid = 1'b1;
			st_nxt.wSt = UAC_W_RESP;
			void'(uac_read(st_r, st_r.awAddr, ok));
			st_nxt.bResp = ok ? UAC_RESP_OKAY : UAC_RESP_SLVERR;
		end
		if (st_r.wSt == UAC_W_RESP && s_axi_bready) begin
			st_nxt.bValid = 1'b0;
			st_nxt.wSt = UAC_W_IDLE;
		end

		// register writes, reserved bits simply not stored
		// only the byte lanes that hold a field are looked at
		if (doWr) begin
			case (st_r.awAddr)
				UAC_AFE_CTRL_OFS: begin
					m = uac_merge(32'h0, st_r.wData, st_r.wStrb);
					if (st_r.wStrb[3]) begin
						st_nxt.term = m[UAC_TERM_BIT]; // R1
						st_nxt.tune = m[UAC_TUNE_MSB:UAC_TUNE_LSB]; // R4
					end
				end
				UAC_LINK_CFG_OFS: begin
					m = uac_merge(32'h0, st_r.wData, st_r.wStrb);
					if (st_r.wStrb[3]) begin
						st_nxt.mode = m[UAC_MODE_BIT]; // R8
					end
					if (st_r.wStrb[2]) begin
						st_nxt.imp = m[UAC_IMP_BIT]; // R10
						st_nxt.slew = m[UAC_SLEW_BIT]; // R11
						st_nxt.swap = m[UAC_SWAP_BIT]; // R12
					end
				end
				UAC_IRQ_EN_OFS: begin
					if (st_r.wStrb[0]) begin
						st_nxt.irqEn = st_r.wData[1:0] & UAC_IRQ_MASK;
					end
				end
				UAC_IRQ_CLR_OFS: begin
					if (st_r.wStrb[0]) begin
						clrEv = st_r.wData[1:0];
					end
				end
				default: m = 32'h0;
			endcase
		end

		// read channel, one outstanding read
		// arready stays low while rvalid stands
		if (st_r.rValid) begin
			if (s_axi_rready) begin
				st_nxt.rValid = 1'b0;
			end
		end else if (s_axi_arvalid) begin
			st_nxt.rData = uac_read(st_r, s_axi_araddr, ok);
			st_nxt.rResp = ok ? UAC_RESP_OKAY : UAC_RESP_SLVERR;
			st_nxt.rValid = 1'b1;
		end

		// live squelch; disconnect only latched at the eop strobe point
		sqNew = afeSquelchN; // R2
		st_nxt.squelchN = sqNew;
		if (eopBit32) begin
			discNew = afeDisconnect; // R3
			st_nxt.disc = discNew;
			if (discNew) begin
				setEv[UAC_IRQ_DISC_BIT] = 1'b1;
			end
		end
		// only the valid-to-invalid edge raises the event, not the level
		if (sqNew && !st_r.squelchN) begin
			setEv[UAC_IRQ_SQ_BIT] = 1'b1;
		end

		// a new event wins over a clear in the same cycle
		st_nxt.irqStat = (st_r.irqStat & ~clrEv) | setEv;
		st_nxt.irqOut = |(st_nxt.irqStat & st_nxt.irqEn);

		// image reload; a fresh image also refreshes the stored copy
		if (imageLoad) begin
			st_nxt.image = imageSel; // R6 R13
		end
		// usb and lite reset restore the last image; tune is skipped while
		// reset protection holds so a tuned trip point survives
		if (usbReset || liteReset) begin
			if (!resetProtect) begin
				st_nxt.tune = st_r.image[5:3]; // R5 R7
			end
			st_nxt.imp = st_r.image[2]; // R7
			st_nxt.slew = st_r.image[1]; // R7
			st_nxt.swap = st_r.image[0]; // R7
		end
		// a fresh image is applied last so it beats a same-cycle reset
		if (imageLoad) begin
			st_nxt.tune = imageSel[5:3]; // R6
			st_nxt.imp = imageSel[2]; // R13
			st_nxt.slew = imageSel[1]; // R13
			st_nxt.swap = imageSel[0]; // R13
		end

		// strap is caught once, on the first clock after reset release
		// later software writes may change the mode freely
		if (!st_r.strapDone) begin
			st_nxt.strapDone = 1'b1;
			st_nxt.mode = portModeStrapPin; // R9
		end

		// ready flops are computed one cycle ahead from the next state so
		// the bus sees a clean flop output instead of decode glitches
		st_nxt.awRdy = uac_slot_free(st_nxt.awHave, st_nxt.wSt);
		st_nxt.wRdy = uac_slot_free(st_nxt.wHave, st_nxt.wSt);
		st_nxt.arRdy = !st_nxt.rValid;
	end

	// single state register; reset takes only constants
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st_r <= '0;
			st_r.wSt <= UAC_W_IDLE;
			st_r.tune <= UAC_TUNE_RST;
			st_r.term <= UAC_BIT_RST; // R1
			st_r.awRdy <= 1'b1; // idle bus accepts at once
			st_r.wRdy <= 1'b1;
			st_r.arRdy <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// write channel handshake, straight from the state flops
	assign s_axi_awready = st_r.awRdy;
	assign s_axi_wready = st_r.wRdy;
	assign s_axi_bvalid = st_r.bValid;
	assign s_axi_bresp = st_r.bResp;

	// read channel handshake
	assign s_axi_arready = st_r.arRdy;
	assign s_axi_rvalid = st_r.rValid;
	assign s_axi_rdata = st_r.rData;
	assign s_axi_rresp = st_r.rResp;

	// analog front end and link controls, plain flop copies
	assign hsTerminationEnable = st_r.term; // R1
	assign squelchTripTune = st_r.tune; // R4
	assign portModeSelect = st_r.mode; // R8
	assign driverImpedanceSelect = st_r.imp; // R10
	assign driverSlewAdjust = st_r.slew; // R11
	assign dataStrobeSwap = st_r.swap; // R12

	// interrupt level, already masked in the flop
	assign irq = st_r.irqOut;
endmodule

//--- verif/uac_regs_checker.sv
`timescale 1ns/1ps
// bus handshake and image load checks, seen from the ports only
module uac_regs_checker
	import uac_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        eepromPresent,
	input wire logic        otpPresent,
	input wire logic [5:0]  eepromBits,
	input wire logic [5:0]  otpBits,
	input wire logic        imageLoad,
	input wire logic        usbReset,
	input wire logic        liteReset,
	input wire logic        resetProtect,
	input wire logic        portModeStrapPin,
	input wire logic        portModeSelect,
	input wire logic [2:0]  squelchTripTune,
	input wire logic        driverImpedanceSelect,
	input wire logic        driverSlewAdjust,
	input wire logic        dataStrobeSwap
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// image fields packed in the same order as the image bits
	wire [5:0] img = {squelchTripTune, driverImpedanceSelect,
		driverSlewAdjust, dataStrobeSwap};
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped");
	property p_arrdy;
		s_axi_arready != s_axi_rvalid;
	endproperty
	a_arrdy: assert property (p_arrdy) else $error("arready not idle-only");
	property p_rlat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rlat: assert property (p_rlat) else $error("read answer late");
	// a write may land up to two cycles after wvalid, so keep clear of it
	property p_tune;
		(usbReset || liteReset) && resetProtect && !imageLoad && !s_axi_wvalid
		&& !$past(s_axi_wvalid) && !$past(s_axi_wvalid, 2)
		|=> $stable(squelchTripTune);
	endproperty
	a_tune: assert property (p_tune) else $error("protected tune reloaded");
	property p_eep;
		imageLoad && eepromPresent |=> img == $past(eepromBits);
	endproperty
	a_eep: assert property (p_eep) else $error("eeprom image not loaded");
	property p_otp;
		imageLoad && !eepromPresent && otpPresent |=> img == $past(otpBits);
	endproperty
	a_otp: assert property (p_otp) else $error("otp image not loaded");
	property p_none;
		imageLoad && !eepromPresent && !otpPresent |=> img == 6'h00;
	endproperty
	a_none: assert property (p_none) else $error("empty image not zero");
	property p_strap;
		$rose(rst_n) |=> portModeSelect == $past(portModeStrapPin);
	endproperty
	a_strap: assert property (p_strap) else $error("mode not from strap");
	c_eep: cover property (imageLoad && eepromPresent);
	c_rd: cover property (s_axi_rvalid && s_axi_rready);
	c_err: cover property (s_axi_bvalid && s_axi_bresp == UAC_RESP_SLVERR);
endmodule
bind uac_regs uac_regs_checker u_chk (.ref_clk, .rst_n, .s_axi_wvalid,
	.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
	.eepromPresent, .otpPresent, .eepromBits, .otpBits, .imageLoad,
	.usbReset, .liteReset, .resetProtect, .portModeStrapPin, .portModeSelect,
	.squelchTripTune, .driverImpedanceSelect, .driverSlewAdjust,
	.dataStrobeSwap);

//--- verif/usb_afe_hsic_config_regs_tb.sv
`timescale 1ns/1ps
// directed checks of the afe control and chip link register bank
module usb_afe_hsic_config_regs_tb
	import uac_pkg::*;
;
	logic        ref_clk = 0, rst_n = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, irq, hsTerminationEnable, portModeSelect;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic        eepromPresent = 0, otpPresent = 0, imageLoad = 0;
	logic        usbReset = 0, liteReset = 0, resetProtect = 0;
	logic        portModeStrapPin = 1, afeSquelchN = 0;
	logic        afeDisconnect = 0, eopBit32 = 0;
	logic [5:0]  eepromBits = 6'h2D, otpBits = 6'h12;
	logic        driverImpedanceSelect, driverSlewAdjust, dataStrobeSwap;
	logic [2:0]  squelchTripTune;
	int          fails = 0, checksDone = 0, cyc = 0;
	always #5 ref_clk = ~ref_clk;
	uac_regs uut (.ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .eepromPresent,
		.otpPresent, .eepromBits, .otpBits, .imageLoad, .usbReset,
		.liteReset, .resetProtect, .portModeStrapPin, .afeSquelchN,
		.afeDisconnect, .eopBit32, .hsTerminationEnable, .squelchTripTune,
		.portModeSelect, .driverImpedanceSelect, .driverSlewAdjust,
		.dataStrobeSwap, .irq);
	task automatic finish_test;
		$display("checks %0d, mismatches %0d", checksDone, fails);
		if (fails == 0 && checksDone > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, g);
		checksDone++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask
	// each valid drops only at the edge that takes it
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!s_axi_bvalid) begin
			@(posedge ref_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end
		rs = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		while (!s_axi_rvalid) begin
			@(posedge ref_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end
		rv = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	// image select and one load pulse, both raised at the same edge
	task automatic ld(input logic e, o);
		@(posedge ref_clk);
		eepromPresent <= e;
		otpPresent <= o;
		imageLoad <= 1'h1;
		@(posedge ref_clk);
		imageLoad <= 1'h0;
		@(posedge ref_clk);
	endtask
	function automatic logic [31:0] img;
		img = {squelchTripTune, driverImpedanceSelect, driverSlewAdjust,
			dataStrobeSwap};
	endfunction
	task automatic t_rw;
		rd(UAC_AFE_CTRL_OFS);
		chk("afe rst", 32'h0, rv);
		rd(UAC_LINK_CFG_OFS);
		chk("link rst", 32'h01000000, rv);
		wr(UAC_AFE_CTRL_OFS, 32'hFFFFFFFF);
		rd(UAC_AFE_CTRL_OFS);
		chk("afe", 32'h27000000, rv);
		chk("term", 1, hsTerminationEnable);
		chk("tune", 7, squelchTripTune);
		wr(UAC_LINK_CFG_OFS, 32'hFFFFFFFF);
		rd(UAC_LINK_CFG_OFS);
		chk("link", 32'h01070000, rv);
		chk("pins", 4'hF, {portModeSelect, driverImpedanceSelect,
			driverSlewAdjust, dataStrobeSwap});
		wr(UAC_LINK_CFG_OFS, 32'h0);
		wr(UAC_AFE_CTRL_OFS, 32'h0);
		chk("pins", 1'h0, portModeSelect);
		chk("term", 1'h0, hsTerminationEnable);
		wr(12'h100, 32'hFFFFFFFF);
		chk("bresp", UAC_RESP_SLVERR, rs);
		rd(12'h100);
		chk("rresp", UAC_RESP_SLVERR, rs);
		chk("rdata", 32'h0, rv);
		$display("register access test done");
	endtask
	task automatic t_image;
		ld(1, 1);
		chk("eep img", 6'h2D, img());
		ld(0, 1);
		chk("otp img", 6'h12, img());
		ld(0, 0);
		chk("no img", 6'h00, img());
		ld(1, 0);
		wr(UAC_AFE_CTRL_OFS, 32'h0);
		resetProtect <= 1'h1;
		usbReset <= 1'h1;
		@(posedge ref_clk);
		usbReset <= 1'h0;
		@(posedge ref_clk);
		chk("protect", 6'h05, img());
		resetProtect <= 1'h0;
		liteReset <= 1'h1;
		@(posedge ref_clk);
		liteReset <= 1'h0;
		@(posedge ref_clk);
		chk("lite", 6'h2D, img());
		$display("image test done");
	endtask
	task automatic t_irq;
		wr(UAC_IRQ_EN_OFS, 32'h3);
		afeSquelchN <= 1'h1;
		rd(UAC_AFE_CTRL_OFS);
		chk("squelch", 32'h10000000, rv & 32'h18000000);
		chk("irq", 1, irq);
		wr(UAC_IRQ_EN_OFS, 32'h0);
		repeat (2) @(posedge ref_clk);
		chk("irq mask", 0, irq);
		wr(UAC_IRQ_CLR_OFS, 32'h1);
		wr(UAC_IRQ_EN_OFS, 32'h3);
		repeat (2) @(posedge ref_clk);
		chk("irq clr", 0, irq);
		afeDisconnect <= 1'h1;
		eopBit32 <= 1'h1;
		@(posedge ref_clk);
		eopBit32 <= 1'h0;
		afeDisconnect <= 1'h0;
		rd(UAC_AFE_CTRL_OFS);
		chk("disc", 32'h18000000, rv & 32'h18000000);
		rd(UAC_IRQ_STAT_OFS);
		chk("status", 32'h2, rv);
		chk("irq", 1, irq);
		$display("interrupt test done");
	endtask
	// second reset in mid-run with the strap low: mode and image clear
	task automatic t_strap;
		@(posedge ref_clk);
		portModeStrapPin <= 1'h0;
		rst_n <= 1'h0;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'h1;
		rd(UAC_LINK_CFG_OFS);
		chk("strap low", 32'h0, rv);
		chk("img rst", 6'h00, img());
		chk("irq rst", 0, irq);
		$display("strap reset test done");
	endtask
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fails++;
			finish_test;
		end
	end
	initial begin
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'h1;
		t_rw;
		t_image;
		t_irq;
		t_strap;
		finish_test;
	end
endmodule
